/* hdl/chip_select_pkg.sv */
/*
  Constants for the midrange and upper peripheral chip-select unit:
  register indexes and byte addresses, field positions, fixed bits,
  reset values and the bus-cycle state encoding.
  Assumes an APB slave with 32-bit data and word-aligned registers.
*/
package chip_select_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned APB_AW = 12;
  localparam logic [7:0] IDX_PERIPH_BASE = 8'ha4;
  localparam logic [7:0] IDX_MIDRANGE = 8'ha6;
  localparam logic [7:0] IDX_AUXILIARY = 8'ha8;
  localparam logic [7:0] IDX_STATUS = 8'haa;
  localparam logic [11:0] ADDR_PERIPH_BASE = {2'b00, IDX_PERIPH_BASE, 2'b00};
  localparam logic [11:0] ADDR_MIDRANGE = {2'b00, IDX_MIDRANGE, 2'b00};
  localparam logic [11:0] ADDR_AUXILIARY = {2'b00, IDX_AUXILIARY, 2'b00};
  localparam logic [11:0] ADDR_STATUS = {2'b00, IDX_STATUS, 2'b00};

  // ----------------------------------------------------------------
  // Fixed bits and reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] AUX_ONES = 16'h8038;
  localparam logic [15:0] MID_ONES = 16'h01f8;
  localparam logic [15:0] PBASE_ONES = 16'h0070;
  localparam logic [15:0] REG_CLEAR = 16'h0000;
  localparam logic [3:0] MID_SEL_IDLE = 4'hf;
  localparam logic [1:0] UP_SEL_IDLE = 2'h3;

  // ----------------------------------------------------------------
  // Fields
  // ----------------------------------------------------------------
  localparam int unsigned SIZE_LSB = 8;
  localparam int unsigned SIZE_W = 7;
  localparam int unsigned PIN_FUNC_BIT = 7;
  localparam int unsigned SPACE_BIT = 6;
  localparam int unsigned READY_BIT = 2;
  localparam int unsigned WAIT_LSB = 0;
  localparam int unsigned WAIT_W = 2;
  localparam int unsigned MID_BASE_LSB = 9;
  localparam int unsigned MID_BASE_W = 7;
  localparam int unsigned PBASE_LSB = 7;
  localparam int unsigned PBASE_W = 9;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 20;
  localparam int unsigned IO_ADDR_W = 16;
  localparam int unsigned MID_TOP_LSB = 13;
  localparam int unsigned QUARTER_LSB = 11;
  localparam int unsigned PBLOCK_LSB = 8;
  localparam int unsigned PBASE_PAD = 11;
  localparam logic [11:0] PBLOCK_UP5 = 12'h005;
  localparam logic [11:0] PBLOCK_UP6 = 12'h006;

  // ----------------------------------------------------------------
  // Status register bits
  // ----------------------------------------------------------------
  localparam int unsigned ST_PBASE_WR = 0;
  localparam int unsigned ST_MID_WR = 1;
  localparam int unsigned ST_AUX_WR = 2;
  localparam int unsigned ST_MID_ON = 3;
  localparam int unsigned ST_UP_CS_ON = 4;
  localparam int unsigned ST_UP_ADDR_ON = 5;
  localparam int unsigned ST_STATE_LSB = 8;
  localparam int unsigned ST_MID_SEL_LSB = 12;
  localparam int unsigned ST_UP_SEL_LSB = 16;

  typedef enum logic [1:0] {
    CYC_IDLE = 2'b00,
    CYC_DECODE = 2'b01,
    CYC_WAIT = 2'b11,
    CYC_DONE = 2'b10
  } cyc_state_t;

endpackage

/* hdl/midrange_peripheral_chip_select.sv */
/*
  Midrange memory selects and upper peripheral selects with their
  configuration registers, wait-state counter and ready handling.
  Assumes an APB master on mclk_i and a processor bus that marks the
  start and end of each bus cycle with one-cycle pulses.
*/
`timescale 1ns/1ps

module midrange_peripheral_chip_select
  import chip_select_pkg::*;
(
  input  wire logic              mclk_i,
  input  wire logic              rst_b_i,
  input  wire logic              ce_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [APB_AW-1:0] paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic      [31:0]       prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  input  wire logic              cyc_start_i,
  input  wire logic              cyc_end_i,
  input  wire logic [ADDR_W-1:0] cyc_addr_i,
  input  wire logic              cyc_mem_i,
  input  wire logic              ext_ready_i,
  output logic      [3:0]        midrange_select_lines_n_o,
  output logic      [1:0]        upper_peripheral_selects_n_o,
  output logic                   cyc_hit_o,
  output logic                   cyc_ready_o
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic [15:0] pbase_q;
  logic [15:0] mid_q;
  logic [15:0] aux_q;
  logic        pbase_wr_q;
  logic        mid_wr_q;
  logic        aux_wr_q;
  logic [31:0] prdata_q;
  logic [31:0] status;
  logic        hit_pbase;
  logic        hit_mid;
  logic        hit_aux;
  logic        hit_status;
  logic        mapped;
  logic        wr_en;

  assign hit_pbase = (paddr_i == ADDR_PERIPH_BASE);
  assign hit_mid = (paddr_i == ADDR_MIDRANGE);
  assign hit_aux = (paddr_i == ADDR_AUXILIARY);
  assign hit_status = (paddr_i == ADDR_STATUS);
  assign mapped = hit_pbase | hit_mid | hit_aux | hit_status;
  assign wr_en = psel_i & penable_i & pwrite_i & ce_i;

  assign pready_o = ce_i;
  assign pslverr_o = psel_i & penable_i & ~mapped;
  assign prdata_o = prdata_q;

  // The fixed bits always read back as ones.
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      pbase_q <= REG_CLEAR | PBASE_ONES;
      mid_q <= REG_CLEAR | MID_ONES;
      aux_q <= REG_CLEAR | AUX_ONES;
    end else if (wr_en) begin
      if (hit_pbase) begin
        pbase_q <= pwdata_i[15:0] | PBASE_ONES;
      end
      if (hit_mid) begin
        mid_q <= pwdata_i[15:0] | MID_ONES;
      end
      if (hit_aux) begin
        aux_q <= pwdata_i[15:0] | AUX_ONES;
      end
    end
  end

  // Write flags gate the selects until software has set them up.
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      pbase_wr_q <= 1'b0;
      mid_wr_q <= 1'b0;
      aux_wr_q <= 1'b0;
    end else if (wr_en) begin
      if (hit_pbase) begin
        pbase_wr_q <= 1'b1;
      end
      if (hit_mid) begin
        mid_wr_q <= 1'b1;
      end
      if (hit_aux) begin
        aux_wr_q <= 1'b1;
      end
    end
  end

  // Read data is captured in the setup cycle.
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q <= 32'h0000_0000;
    end else if (ce_i && psel_i && !penable_i && !pwrite_i) begin
      if (hit_pbase) begin
        prdata_q <= {16'h0000, pbase_q};
      end else if (hit_mid) begin
        prdata_q <= {16'h0000, mid_q};
      end else if (hit_aux) begin
        prdata_q <= {16'h0000, aux_q};
      end else if (hit_status) begin
        prdata_q <= status;
      end else begin
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration fields
  // ----------------------------------------------------------------
  logic [SIZE_W-1:0]     size_f;
  logic [MID_BASE_W-1:0] mid_base_f;
  logic [MID_BASE_W-1:0] mid_mask;
  logic [PBASE_W-1:0]    pbase_f;
  logic                  pin_cs;
  logic                  mid_on;
  logic                  up_cs_on;
  logic                  up_addr_on;

  assign size_f = aux_q[SIZE_LSB +: SIZE_W];
  assign mid_base_f = mid_q[MID_BASE_LSB +: MID_BASE_W];
  assign mid_mask = ~(size_f - 7'h01);
  assign pbase_f = pbase_q[PBASE_LSB +: PBASE_W];
  assign pin_cs = aux_q[PIN_FUNC_BIT];
  assign mid_on = mid_wr_q & aux_wr_q & $onehot(size_f);
  assign up_cs_on = pbase_wr_q & aux_wr_q & pin_cs;
  assign up_addr_on = aux_wr_q & ~pin_cs;

  // ----------------------------------------------------------------
  // Bus cycle decode
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] lat_addr_q;
  logic              lat_mem_q;
  logic [ADDR_W-1:0] eff_addr;
  logic [ADDR_W-1:0] up_off;
  logic [11:0]       up_block;
  logic              space_ok;
  logic              mid_hit;
  logic              up5_hit;
  logic              up6_hit;
  logic [1:0]        quarter;
  logic              sel_ign_rdy;
  logic [WAIT_W-1:0] sel_wait;

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      lat_addr_q <= {ADDR_W{1'b0}};
      lat_mem_q <= 1'b0;
    end else if (ce_i && cyc_start_i) begin
      lat_addr_q <= cyc_addr_i;
      lat_mem_q <= cyc_mem_i;
    end
  end

  // Lower base bits a12 to a0 are zero, so only a19 to a13 compare.
  assign mid_hit = mid_on & lat_mem_q
    & ((lat_addr_q[ADDR_W-1:MID_TOP_LSB] & mid_mask) == (mid_base_f & mid_mask));

  // The quarter sits just above the per-select size.
  always_comb begin
    quarter = 2'b00;
    for (int k = 0; k < SIZE_W; k++) begin
      if (size_f[k]) begin
        quarter = lat_addr_q[QUARTER_LSB + k +: 2];
      end
    end
  end

  // I/O cycles only carry sixteen address bits.
  assign eff_addr = lat_mem_q ? lat_addr_q : {{(ADDR_W-IO_ADDR_W){1'b0}}, lat_addr_q[IO_ADDR_W-1:0]};
  assign up_off = eff_addr - {pbase_f, {PBASE_PAD{1'b0}}};
  assign up_block = up_off[ADDR_W-1:PBLOCK_LSB];
  assign space_ok = (aux_q[SPACE_BIT] == lat_mem_q);
  assign up5_hit = up_cs_on & space_ok & (up_block == PBLOCK_UP5);
  assign up6_hit = up_cs_on & space_ok & (up_block == PBLOCK_UP6);

  // Timing comes from whichever select owns the cycle.
  always_comb begin
    if (up5_hit || up6_hit) begin
      sel_ign_rdy = aux_q[READY_BIT];
      sel_wait = aux_q[WAIT_LSB +: WAIT_W];
    end else begin
      sel_ign_rdy = mid_q[READY_BIT];
      sel_wait = mid_q[WAIT_LSB +: WAIT_W];
    end
  end

  // ----------------------------------------------------------------
  // Bus cycle sequence
  // ----------------------------------------------------------------
  cyc_state_t        state_q;
  logic [WAIT_W-1:0] wait_q;
  logic              ign_rdy_q;
  logic              hit_q;
  logic [3:0]        mid_sel_n_q;
  logic [1:0]        up_sel_n_q;

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= CYC_IDLE;
    end else if (ce_i) begin
      if (cyc_end_i) begin
        state_q <= CYC_IDLE;
      end else begin
        case (state_q)
          CYC_IDLE: begin
            if (cyc_start_i) begin
              state_q <= CYC_DECODE;
            end
          end
          CYC_DECODE: begin
            if (mid_hit || up5_hit || up6_hit) begin
              state_q <= CYC_WAIT;
            end else begin
              state_q <= CYC_DONE;
            end
          end
          CYC_WAIT: begin
            if (wait_q == 2'b00 && (ign_rdy_q || ext_ready_i)) begin
              state_q <= CYC_DONE;
            end
          end
          CYC_DONE: begin
            state_q <= CYC_DONE;
          end
          default: begin
            state_q <= CYC_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      wait_q <= 2'b00;
      ign_rdy_q <= 1'b0;
      hit_q <= 1'b0;
    end else if (ce_i) begin
      if (cyc_end_i) begin
        hit_q <= 1'b0;
      end else if (state_q == CYC_DECODE) begin
        wait_q <= sel_wait;
        ign_rdy_q <= sel_ign_rdy;
        hit_q <= mid_hit | up5_hit | up6_hit;
      end else if (state_q == CYC_WAIT && wait_q != 2'b00) begin
        wait_q <= wait_q - 2'b01;
      end
    end
  end

  // Midrange selects load one edge after the address latch.
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      mid_sel_n_q <= MID_SEL_IDLE;
    end else if (ce_i) begin
      if (cyc_end_i || !mid_on) begin
        mid_sel_n_q <= MID_SEL_IDLE;
      end else if (state_q == CYC_DECODE) begin
        mid_sel_n_q <= mid_hit ? ~(4'b0001 << quarter) : MID_SEL_IDLE;
      end
    end
  end

  // Upper pins carry either chip selects or latched a1 and a2.
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      up_sel_n_q <= UP_SEL_IDLE;
    end else if (ce_i) begin
      if (up_addr_on) begin
        up_sel_n_q <= {lat_addr_q[1], lat_addr_q[2]};
      end else if (cyc_end_i || !up_cs_on) begin
        up_sel_n_q <= UP_SEL_IDLE;
      end else if (state_q == CYC_DECODE) begin
        up_sel_n_q <= {~up6_hit, ~up5_hit};
      end
    end
  end

  assign midrange_select_lines_n_o = mid_sel_n_q;
  assign upper_peripheral_selects_n_o = up_sel_n_q;
  assign cyc_hit_o = hit_q;
  assign cyc_ready_o = hit_q & (state_q == CYC_DONE);

  // ----------------------------------------------------------------
  // Status word
  // ----------------------------------------------------------------
  always_comb begin
    status = 32'h0000_0000;
    status[ST_PBASE_WR] = pbase_wr_q;
    status[ST_MID_WR] = mid_wr_q;
    status[ST_AUX_WR] = aux_wr_q;
    status[ST_MID_ON] = mid_on;
    status[ST_UP_CS_ON] = up_cs_on;
    status[ST_UP_ADDR_ON] = up_addr_on;
    status[ST_STATE_LSB +: 2] = state_q;
    status[ST_MID_SEL_LSB +: 4] = mid_sel_n_q;
    status[ST_UP_SEL_LSB +: 2] = up_sel_n_q;
  end

endmodule

/* tb/cs_checker_assertions.sv */
/*
  Port checker for the midrange and upper chip-select unit.
  Assumes bus cycles start only while idle and end before the next starts.
*/
`timescale 1ns/1ps

module cs_checker (
  input wire logic       mclk_i,
  input wire logic       rst_b_i,
  input wire logic       ce_i,
  input wire logic       psel_i,
  input wire logic       penable_i,
  input wire logic       cyc_start_i,
  input wire logic       cyc_end_i,
  input wire logic       pready_o,
  input wire logic       pslverr_o,
  input wire logic [3:0] midrange_select_lines_n_o,
  input wire logic       cyc_hit_o,
  input wire logic       cyc_ready_o
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  sequence cyc_open;
    cyc_start_i && ce_i;
  endsequence

  sequence cyc_close;
    cyc_end_i && ce_i;
  endsequence

  apb_ready_a: assert property (pready_o == ce_i) else $error("pready differs from ce");
  apb_err_a: assert property (pslverr_o |-> psel_i && penable_i) else $error("error outside access");
  mid_onehot_a: assert property ($onehot0(~midrange_select_lines_n_o))
    else $error("more than one midrange select");
  mid_hit_a: assert property ((midrange_select_lines_n_o != 4'hf) |-> cyc_hit_o)
    else $error("midrange select without hit");
  start_quiet_a: assert property (cyc_open |=> midrange_select_lines_n_o == 4'hf)
    else $error("select asserted too early");
  hit_late_a: assert property ($rose(cyc_hit_o) |-> $past(cyc_start_i, 2))
    else $error("hit not two cycles after start");
  sel_release_a: assert property (cyc_close |=> midrange_select_lines_n_o == 4'hf && !cyc_hit_o && !cyc_ready_o)
    else $error("selects held after cycle end");
  sel_hold_a: assert property (cyc_hit_o && !cyc_end_i |=> $stable(midrange_select_lines_n_o))
    else $error("select changed inside cycle");
  ready_hit_a: assert property (cyc_ready_o |-> cyc_hit_o && $past(cyc_hit_o))
    else $error("ready without hit");
  ready_wait_a: assert property ($rose(cyc_ready_o) |-> $past(cyc_hit_o))
    else $error("ready before wait phase");
endmodule

bind midrange_peripheral_chip_select cs_checker u_chk (
  .mclk_i(mclk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .psel_i(psel_i), .penable_i(penable_i),
  .cyc_start_i(cyc_start_i), .cyc_end_i(cyc_end_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .midrange_select_lines_n_o(midrange_select_lines_n_o), .cyc_hit_o(cyc_hit_o), .cyc_ready_o(cyc_ready_o)
);

/* tb/mem_partner.sv */
/*
  External memory and peripheral model: answers ready a set number
  of cycles after any of its selects goes low.
  Assumes selects are active low and ready is active high.
*/
`timescale 1ns/1ps

module mem_partner (
  input wire logic       mclk_i,
  input wire logic       rst_b_i,
  input wire logic [3:0] mid_sel_n_i,
  input wire logic [1:0] up_sel_n_i,
  input wire logic [3:0] dly_i,
  output logic           ready_o
);
  logic [3:0] cnt_q;
  logic       sel;

  assign sel = (mid_sel_n_i != 4'hf) || (up_sel_n_i != 2'h3);

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q <= 4'h0;
    end else if (!sel) begin
      cnt_q <= 4'h0;
    end else if (cnt_q != 4'hf) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end

  // Ready is driven low again once the device is deselected.
  assign ready_o = sel && (cnt_q >= dly_i);
endmodule

/* tb/tb.sv */
/*
  Testbench for the chip-select unit: registers over APB, bus cycles
  against the memory model, timing and select checks.
  Assumes the design package and the checker bind are compiled first.
*/
`timescale 1ns/1ps

module tb;
  import chip_select_pkg::*;
  logic        mclk_i, rst_b_i, ce_i, psel, penable, pwrite, cyc_start, cyc_end, cyc_mem;
  logic        pready, pslverr, ext_ready, hit, rdy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [19:0] cyc_addr;
  logic [3:0]  mid_n, dly;
  logic [1:0]  up_n;
  int          bad_count, n_compared, n;
  logic [3:0]  ms;
  logic [1:0]  us;

  midrange_peripheral_chip_select DUT (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .cyc_start_i(cyc_start), .cyc_end_i(cyc_end), .cyc_addr_i(cyc_addr),
    .cyc_mem_i(cyc_mem), .ext_ready_i(ext_ready), .midrange_select_lines_n_o(mid_n),
    .upper_peripheral_selects_n_o(up_n), .cyc_hit_o(hit), .cyc_ready_o(rdy));
  mem_partner u_mem (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .mid_sel_n_i(mid_n), .up_sel_n_i(up_n),
    .dly_i(dly), .ready_o(ext_ready));

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d, input logic [31:0] x,
                     input logic xe);
    @(posedge mclk_i);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge mclk_i);
    penable <= 1'h1;
    do begin
      @(posedge mclk_i);
    end while (pready !== 1'h1);
    if (!w) chk("read data", x, prdata);
    chk("slave error", 32'(xe), 32'(pslverr));
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic cyc(input logic [19:0] a, input logic m);
    @(posedge mclk_i);
    cyc_start <= 1'h1;
    cyc_addr <= a;
    cyc_mem <= m;
    @(posedge mclk_i);
    cyc_start <= 1'h0;
    n = 0;
    ms = 4'hf;
    us = 2'h3;
    while (n < 20 && rdy !== 1'h1) begin
      @(posedge mclk_i);
      n++;
      if (mid_n !== 4'hf) begin
        ms = mid_n;
      end
      if (up_n !== 2'h3) begin
        us = up_n;
      end
    end
    cyc_end <= 1'h1;
    @(posedge mclk_i);
    cyc_end <= 1'h0;
  endtask

  task automatic do_reset;
    rst_b_i <= 1'h0;
    repeat (2) @(posedge mclk_i);
    rst_b_i <= 1'h1;
    repeat (3) @(posedge mclk_i);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    chk("pins idle", 32'h0000_003f, 32'({mid_n, up_n}));
    apb(1'h0, ADDR_MIDRANGE, 16'h0000, 32'(MID_ONES), 1'h0);
    apb(1'h0, 12'h004, 16'h0000, 32'h0000_0000, 1'h1);
    apb(1'h1, ADDR_MIDRANGE, MID_ONES | 16'h0004, 32'h0000_0000, 1'h0);
    cyc(20'h0_1800, 1'h1);
    chk("one reg only", 32'h0000_000f, 32'(ms));
    apb(1'h1, ADDR_AUXILIARY, 16'h81bc, 32'h0000_0000, 1'h0);
    cyc(20'h0_0500, 1'h0);
    chk("upper no base", 32'h0000_0003, 32'(us));
    cyc(20'h0_1800, 1'h1);
    chk("both regs", 32'h0000_0007, 32'(ms));
    apb(1'h0, ADDR_STATUS, 16'h0000, 32'h0003_f00e, 1'h0);
  endtask

  task automatic t_freeze;
    ce_i <= 1'h0;
    cyc(20'h2_8000, 1'h1);
    chk("frozen start", 32'h0000_000f, 32'(ms));
    ce_i <= 1'h1;
    cyc(20'h2_8000, 1'h1);
    chk("after freeze", 32'h0000_000e, 32'(ms));
  endtask

  task automatic t_sizes;
    logic [15:0] aux;
    logic [19:0] blk;
    for (int k = 0; k < 7; k++) begin
      aux = AUX_ONES | (16'h0100 << k) | 16'h0084;
      blk = 20'h0_2000 << k;
      apb(1'h1, ADDR_AUXILIARY, aux, 32'h0000_0000, 1'h0);
      apb(1'h0, ADDR_AUXILIARY, 16'h0000, 32'(aux), 1'h0);
      apb(1'h1, ADDR_MIDRANGE, MID_ONES | 16'h0004 | 16'(k % 4), 32'h0000_0000, 1'h0);
      cyc(blk - 20'h0_0001, 1'h1);
      chk("top quarter", 32'h0000_0007, 32'(ms));
      chk("wait states", 32'(3 + k % 4), 32'(n));
      cyc(blk >> 2, 1'h1);
      chk("second quarter", 32'h0000_000d, 32'(ms));
      cyc(blk, 1'h1);
      chk("past block", 32'h0000_000f, 32'(ms));
    end
  endtask

  task automatic t_base;
    apb(1'h1, ADDR_AUXILIARY, 16'h84bc, 32'h0000_0000, 1'h0);
    apb(1'h1, ADDR_MIDRANGE, 16'h29fc, 32'h0000_0000, 1'h0);
    for (int q = 0; q < 4; q++) begin
      cyc(20'h2_8000 + 20'(q) * 20'h0_2000, 1'h1);
      chk("base quarter", {28'h000_0000, ~(4'h1 << q)}, 32'(ms));
    end
    cyc(20'h2_7fff, 1'h1);
    chk("below base", 32'h0000_000f, 32'(ms));
    cyc(20'h3_0000, 1'h1);
    chk("above block", 32'h0000_000f, 32'(ms));
  endtask

  task automatic t_ready;
    apb(1'h1, ADDR_MIDRANGE, 16'h29f9, 32'h0000_0000, 1'h0);
    dly <= 4'h5;
    cyc(20'h2_8000, 1'h1);
    chk("mid ext ready", 32'h0000_0001, 32'(n >= 8 && n <= 9));
    dly <= 4'h0;
    cyc(20'h2_8000, 1'h1);
    chk("mid wait only", 32'h0000_0004, 32'(n));
  endtask

  task automatic t_upper;
    apb(1'h1, ADDR_PERIPH_BASE, 16'h1070, 32'h0000_0000, 1'h0);
    apb(1'h1, ADDR_AUXILIARY, 16'h84fe, 32'h0000_0000, 1'h0);
    cyc(20'h1_0500, 1'h1);
    chk("upper five", 32'h0000_0002, 32'(us));
    chk("upper waits", 32'h0000_0005, 32'(n));
    cyc(20'h1_0600, 1'h1);
    chk("upper six", 32'h0000_0001, 32'(us));
    apb(1'h1, ADDR_PERIPH_BASE, 16'h0070, 32'h0000_0000, 1'h0);
    cyc(20'h0_0500, 1'h0);
    chk("io not mem", 32'h0000_0003, 32'(us));
    apb(1'h1, ADDR_AUXILIARY, 16'h84b8, 32'h0000_0000, 1'h0);
    dly <= 4'h5;
    cyc(20'h0_0600, 1'h0);
    chk("io six", 32'h0000_0001, 32'(us));
    chk("upper ext ready", 32'h0000_0001, 32'(n >= 8 && n <= 9));
    dly <= 4'h0;
    cyc(20'h0_0600, 1'h1);
    chk("mem not io", 32'h0000_0003, 32'(us));
  endtask

  task automatic t_addr;
    cyc(20'h0_0006, 1'h1);
    chk("pins before aux", 32'h0000_0003, 32'(up_n));
    apb(1'h1, ADDR_AUXILIARY, 16'h8138, 32'h0000_0000, 1'h0);
    cyc(20'h0_0002, 1'h1);
    chk("a1 high", 32'h0000_0002, 32'(up_n));
    cyc(20'h0_0004, 1'h1);
    chk("a2 high", 32'h0000_0001, 32'(up_n));
  endtask

  task automatic results;
    if (bad_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    mclk_i = 1'h0;
    forever #25 mclk_i = ~mclk_i;
  end

  initial begin
    #2000000;
    bad_count++;
    results;
  end

  initial begin
    {rst_b_i, psel, penable, pwrite, cyc_start, cyc_end, cyc_mem} = 7'h00;
    ce_i = 1'h1;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    cyc_addr = 20'h0_0000;
    dly = 4'h0;
    bad_count = 0;
    n_compared = 0;
    do_reset;
    t_reset;
    t_sizes;
    t_base;
    t_freeze;
    t_ready;
    t_upper;
    do_reset;
    t_addr;
    results;
  end
endmodule
